// ===== include/ite_pkg.sv
// constants and types shared by the interval timer with edge select
`default_nettype none
package ite_pkg;

  // ****************************************
  // bus and register map (register indices, byte address = 4 * index)
  // ****************************************
  localparam int ITE_ADDR_W = 18;
  localparam logic [15:0] IDX_SAMPLE_CLOCK_SELECT = 16'hFF47;
  localparam logic [15:0] IDX_EXTERNAL_EDGE_MODE = 16'hFFEC;
  localparam logic [15:0] IDX_TIMER_MODE_CONTROL = 16'hFF60;
  localparam logic [15:0] IDX_TIMER_CLOCK_SELECT = 16'hFF61;
  localparam logic [15:0] IDX_COMPARE_ZERO = 16'hFF62;
  localparam logic [15:0] IDX_TIMER_COUNT = 16'hFF63;
  localparam logic [15:0] IDX_OSC_MODE = 16'hFF64;
  localparam logic [15:0] IDX_CPU_CLOCK_CONTROL = 16'hFF65;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hFF66;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hFF67;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_EDGE_MODE = 8'h00;
  localparam logic [1:0] RST_SAMPLE_SEL = 2'h0;
  localparam logic [2:0] RST_CLK_SEL = 3'h0;
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [15:0] RST_COMPARE = 16'h0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic RST_OSC_MODE = 1'h0;
  localparam logic [2:0] RST_CPU_N = 3'h0;
  localparam logic [3:0] RST_STATUS = 4'h0;
  localparam logic [3:0] RST_MASK = 4'h0;

  // ****************************************
  // field positions
  // ****************************************
  localparam int EDGE_FIRST_LSB = 2;
  localparam int EDGE_SECOND_LSB = 4;
  localparam int EDGE_THIRD_LSB = 6;
  localparam int SAMPLE_SEL_LSB = 0;
  localparam int CLK_SEL_LSB = 4;
  localparam int MODE_LSB = 1;
  localparam int CPU_N_LSB = 0;
  localparam int OSC_MODE_LSB = 0;
  localparam logic [7:0] EDGE_MODE_WMASK = 8'hFC;

  // ****************************************
  // encodings
  // ****************************************
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [2:0] MODE_STOP = 3'h0;
  localparam logic [2:0] MODE_INTERVAL = 3'h6;
  localparam logic [1:0] SMP_CPU = 2'h0;

  // sampling dividers as powers of two, per oscillation mode
  localparam logic [3:0] SMP_EXP_M1_C1 = 4'h7;
  localparam logic [3:0] SMP_EXP_M1_C2 = 4'h5;
  localparam logic [3:0] SMP_EXP_M1_C3 = 4'h6;
  localparam logic [3:0] SMP_EXP_M0_C1 = 4'h8;
  localparam logic [3:0] SMP_EXP_M0_C2 = 4'h6;
  localparam logic [3:0] SMP_EXP_M0_C3 = 4'h7;
  localparam int PRESC_W = 9;

  // count clock sources of the timer clock field
  typedef enum logic [2:0] {
    CNT_PIN = 3'h0,
    CNT_DIV_A = 3'h1,
    CNT_DIV_B = 3'h2,
    CNT_DIV_C = 3'h3,
    CNT_DIV_D = 3'h4,
    CNT_BAD_5 = 3'h5,
    CNT_BAD_6 = 3'h6,
    CNT_WATCH = 3'h7
  } ite_cnt_src_e;

  // one-cycle events gathered into the sticky status
  typedef struct packed {
    logic cmpMatch;
    logic irqThird;
    logic irqSecond;
    logic irqFirst;
  } ite_events_s;

endpackage : ite_pkg
`default_nettype wire

// ===== verilog/ite_interval_timer.sv
// interval timer with external edge select, noise sampling and avalon-mm registers
//
// Function
// - edge mode register clears to zero on reset.
// - three 2-bit fields each pick the valid edge of one external input.
// - field 00 falling, 01 rising, 11 both; 10 must not be written.
// - sampling clock select register clears to zero on reset.
// - first input is sampled by the selected sampling clock to reject noise.
// - sampling code 00 cpu clock; others oscillator over 2^7/5/6 or 2^8/6/7.
// - cpu clock sampling stops while the processor halts.
// - cpu clock exponent comes from low three bits of cpu clock control.
// - in interval mode a compare match clears count, continues, raises interrupt.
// - interval period is compare value plus one count clock ticks.
// - count clock chosen by bits 4 to 6 of the timer clock select.
// - count code 000 counts valid edges of the timer input pin.
// - internal codes give 1,2,4,8 cycles, or prohibited,1,2,4 with mode bit set.
// - code 111 counts watch timer edges; 101 and 110 are prohibited.
// - a first input edge counts only after two equal successive samples.
//
// Our own choice: the Avalon-MM slave port.
`default_nettype none
module ite_interval_timer
  import ite_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [ITE_ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  input wire logic extIrqFirst,
  input wire logic extIrqSecond,
  input wire logic extIrqThird,
  input wire logic watchTimerOut,
  input wire logic cpuHalt,
  output logic compareMatchIrq,
  output logic irq
);

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] edgeMode_q;
  logic [1:0] sampleSel_q;
  logic [2:0] clkSel_q;
  logic [2:0] mode_q;
  logic [15:0] compare_q;
  logic [15:0] count_q;
  logic oscMode_q;
  logic [2:0] cpuN_q;
  logic [3:0] status_q;
  logic [3:0] mask_q;
  logic [PRESC_W-1:0] presc_q;
  logic sample_q;
  logic filt_q;
  logic second_q;
  logic third_q;
  logic watch_q;
  logic pending_q;
  logic [31:0] readdata_q;
  logic match_q;

  // ****************************************
  // helpers
  // ****************************************
  // decode a 2-bit edge field against an old and a new level
  function automatic logic edgeHit(input logic [1:0] code, input logic oldLvl, input logic newLvl);
    logic hit;
    hit = 1'b0;
    unique case (code)
      EDGE_FALL: hit = oldLvl & ~newLvl;
      EDGE_RISE: hit = ~oldLvl & newLvl;
      EDGE_BOTH: hit = oldLvl ^ newLvl;
      default: hit = 1'b0; // code 10 is prohibited, no edge
    endcase
    return hit;
  endfunction : edgeHit

  // one-cycle tick every 2^exp oscillator cycles
  function automatic logic divTick(input logic [PRESC_W-1:0] presc, input logic [3:0] exp);
    logic [PRESC_W-1:0] m;
    m = PRESC_W'((10'h001 << exp) - 10'h001);
    return (presc & m) == m;
  endfunction : divTick

  // ****************************************
  // bus decode
  // ****************************************
  // one wait state: the request is answered in its second cycle
  wire logic busReq = avsRead | avsWrite;
  wire logic accept = busReq & pending_q;
  wire logic [15:0] idx = avsAddress[ITE_ADDR_W-1:2];
  wire logic wrAcc = accept & avsWrite;
  wire logic rdAcc = accept & avsRead;
  wire logic be0 = avsByteenable[0];
  wire logic be1 = avsByteenable[1];
  wire logic [7:0] wLo = avsWritedata[7:0];
  wire logic [7:0] wHi = avsWritedata[15:8];
  wire logic wrEdge = wrAcc & be0 & (idx == IDX_EXTERNAL_EDGE_MODE);
  wire logic wrSample = wrAcc & be0 & (idx == IDX_SAMPLE_CLOCK_SELECT);
  wire logic wrMode = wrAcc & be0 & (idx == IDX_TIMER_MODE_CONTROL);
  wire logic wrClk = wrAcc & be0 & (idx == IDX_TIMER_CLOCK_SELECT);
  wire logic wrCmp = wrAcc & (idx == IDX_COMPARE_ZERO);
  wire logic wrOsc = wrAcc & be0 & (idx == IDX_OSC_MODE);
  wire logic wrCpu = wrAcc & be0 & (idx == IDX_CPU_CLOCK_CONTROL);
  wire logic wrMask = wrAcc & be0 & (idx == IDX_IRQ_MASK);
  wire logic rdStatus = rdAcc & (idx == IDX_IRQ_STATUS);
  wire logic [15:0] cmpWr = {be1 ? wHi : compare_q[15:8], be0 ? wLo : compare_q[7:0]};

  // read multiplexer, unmapped addresses read as zero
  wire logic [31:0] rdMux =
    (idx == IDX_EXTERNAL_EDGE_MODE) ? {24'h000000, edgeMode_q} :
    (idx == IDX_SAMPLE_CLOCK_SELECT) ? {30'h00000000, sampleSel_q} :
    (idx == IDX_TIMER_MODE_CONTROL) ? {28'h0000000, mode_q, 1'b0} :
    (idx == IDX_TIMER_CLOCK_SELECT) ? {25'h0000000, clkSel_q, 4'h0} :
    (idx == IDX_COMPARE_ZERO) ? {16'h0000, compare_q} :
    (idx == IDX_TIMER_COUNT) ? {16'h0000, count_q} :
    (idx == IDX_OSC_MODE) ? {31'h00000000, oscMode_q} :
    (idx == IDX_CPU_CLOCK_CONTROL) ? {29'h00000000, cpuN_q} :
    (idx == IDX_IRQ_STATUS) ? {28'h0000000, status_q} :
    (idx == IDX_IRQ_MASK) ? {28'h0000000, mask_q} :
    32'h00000000;

  assign avsWaitrequest = busReq & ~pending_q;
  assign avsReaddata = readdata_q;

  // ****************************************
  // field views
  // ****************************************
  wire logic [1:0] edgeFirst = edgeMode_q[EDGE_FIRST_LSB +: 2];
  wire logic [1:0] edgeSecond = edgeMode_q[EDGE_SECOND_LSB +: 2];
  wire logic [1:0] edgeThird = edgeMode_q[EDGE_THIRD_LSB +: 2];
  wire ite_cnt_src_e cntSrc = ite_cnt_src_e'(clkSel_q);

  // ****************************************
  // sampling clock for the first input
  // ****************************************
  // cpu clock runs at the oscillator, or half of it in mode 0, over 2^N
  wire logic [3:0] cpuExp = {1'b0, cpuN_q} + {3'h0, ~oscMode_q};
  wire logic [3:0] smpExp =
    (sampleSel_q == 2'h1) ? (oscMode_q ? SMP_EXP_M1_C1 : SMP_EXP_M0_C1) :
    (sampleSel_q == 2'h2) ? (oscMode_q ? SMP_EXP_M1_C2 : SMP_EXP_M0_C2) :
    (sampleSel_q == 2'h3) ? (oscMode_q ? SMP_EXP_M1_C3 : SMP_EXP_M0_C3) :
    cpuExp;
  wire logic cpuStopped = (sampleSel_q == SMP_CPU) & cpuHalt;
  wire logic smpTick = divTick(presc_q, smpExp) & ~cpuStopped;

  // new level is taken only when two successive samples agree
  wire logic firstStable = smpTick & (extIrqFirst == sample_q);
  wire logic filtNext = firstStable ? extIrqFirst : filt_q;

  // ****************************************
  // edge events
  // ****************************************
  // the first input edge also feeds the timer; its field is written whether the timer runs or is stopped
  wire logic firstEdge = edgeHit(edgeFirst, filt_q, filtNext);
  wire logic secondEdge = edgeHit(edgeSecond, second_q, extIrqSecond);
  wire logic thirdEdge = edgeHit(edgeThird, third_q, extIrqThird);
  wire logic watchEdge = watchTimerOut & ~watch_q;

  // ****************************************
  // count clock selection
  // ****************************************
  wire logic tick1 = 1'b1;
  wire logic tick2 = divTick(presc_q, 4'h1);
  wire logic tick4 = divTick(presc_q, 4'h2);
  wire logic tick8 = divTick(presc_q, 4'h3);
  wire logic cntTick =
    (cntSrc == CNT_PIN) ? firstEdge :
    (cntSrc == CNT_DIV_A) ? (~oscMode_q & tick1) :
    (cntSrc == CNT_DIV_B) ? (oscMode_q ? tick1 : tick2) :
    (cntSrc == CNT_DIV_C) ? (oscMode_q ? tick2 : tick4) :
    (cntSrc == CNT_DIV_D) ? (oscMode_q ? tick4 : tick8) :
    (cntSrc == CNT_WATCH) ? watchEdge :
    1'b0;

  // ****************************************
  // counter next value
  // ****************************************
  wire logic running = (mode_q != MODE_STOP);
  wire logic interval = (mode_q == MODE_INTERVAL);
  wire logic cmpHit = running & cntTick & interval & (count_q == compare_q);
  wire logic [15:0] countNext =
    ~running ? RST_COUNT :
    cmpHit ? RST_COUNT :
    cntTick ? count_q + 16'h0001 :
    count_q;

  // ****************************************
  // interrupt status
  // ****************************************
  wire ite_events_s events = '{cmpMatch: cmpHit, irqThird: thirdEdge, irqSecond: secondEdge, irqFirst: firstEdge};
  wire logic [3:0] clrBits = rdStatus ? readdata_q[3:0] : 4'h0;
  // only reported bits clear, and a new event wins over the clear
  wire logic [3:0] statusNext = (status_q & ~clrBits) | events;

  assign irq = |(status_q & mask_q);
  assign compareMatchIrq = match_q;

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      edgeMode_q <= RST_EDGE_MODE;
      sampleSel_q <= RST_SAMPLE_SEL;
      clkSel_q <= RST_CLK_SEL;
      mode_q <= RST_MODE;
      oscMode_q <= RST_OSC_MODE;
      cpuN_q <= RST_CPU_N;
      mask_q <= RST_MASK;
    end
    else
    begin
      if (wrEdge)
        edgeMode_q <= wLo & EDGE_MODE_WMASK;
      if (wrSample)
        sampleSel_q <= wLo[SAMPLE_SEL_LSB +: 2];
      if (wrClk)
        clkSel_q <= wLo[CLK_SEL_LSB +: 3];
      if (wrMode)
        mode_q <= wLo[MODE_LSB +: 3];
      if (wrOsc)
        oscMode_q <= wLo[OSC_MODE_LSB];
      if (wrCpu)
        cpuN_q <= wLo[CPU_N_LSB +: 3];
      if (wrMask)
        mask_q <= wLo[3:0];
    end
  end

  // ****************************************
  // compare and count registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      compare_q <= RST_COMPARE;
      count_q <= RST_COUNT;
      match_q <= 1'b0;
    end
    else
    begin
      if (wrCmp)
        compare_q <= cmpWr;
      count_q <= countNext;
      match_q <= cmpHit;
    end
  end

  // ****************************************
  // sampling, edge history and prescaler
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      presc_q <= '0;
      sample_q <= 1'b0;
      filt_q <= 1'b0;
      second_q <= 1'b0;
      third_q <= 1'b0;
      watch_q <= 1'b0;
    end
    else
    begin
      presc_q <= presc_q + PRESC_W'(1);
      if (smpTick)
        sample_q <= extIrqFirst;
      filt_q <= filtNext;
      second_q <= extIrqSecond;
      third_q <= extIrqThird;
      watch_q <= watchTimerOut;
    end
  end

  // ****************************************
  // bus answer and status
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pending_q <= 1'b0;
      readdata_q <= 32'h00000000;
      status_q <= RST_STATUS;
    end
    else
    begin
      pending_q <= busReq & ~pending_q;
      if (busReq & ~pending_q)
        readdata_q <= rdMux;
      status_q <= statusNext;
    end
  end

endmodule : ite_interval_timer
`default_nettype wire

// ===== sim/ite_interval_timer_checker.sv
// port assertions for the interval timer with edge select
`default_nettype none
module ite_interval_timer_checker
  import ite_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [ITE_ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  input wire logic [31:0] avsReaddata,
  input wire logic avsWaitrequest,
  input wire logic extIrqFirst,
  input wire logic extIrqSecond,
  input wire logic extIrqThird,
  input wire logic watchTimerOut,
  input wire logic cpuHalt,
  input wire logic compareMatchIrq,
  input wire logic irq
);
  // ****************************************
  // bus, interrupt and timer output checks
  // ****************************************
  wire logic req = avsRead | avsWrite;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_wait_first: assert property ($rose(req) |-> avsWaitrequest)
    else $error("new request not held off");
  a_wait_one: assert property (req && avsWaitrequest |=> !avsWaitrequest)
    else $error("more than one wait state");
  a_idle_nowait: assert property (!req |-> !avsWaitrequest)
    else $error("wait request while idle");
  a_rdata_hold: assert property (!$past(req) |-> $stable(avsReaddata))
    else $error("read data moved without request");
  a_reset_rdata: assert property ($past(srst) |-> avsReaddata == 32'h0)
    else $error("read data not cleared by reset");
  a_reset_quiet: assert property ($past(srst) |-> !irq && !compareMatchIrq)
    else $error("interrupt active out of reset");
  a_irq_fall: assert property ($fell(irq) |-> $past(req && !avsWaitrequest))
    else $error("interrupt dropped without access");
  a_cmp_single: assert property (compareMatchIrq |=> !compareMatchIrq)
    else $error("compare pulse longer than a cycle");
endmodule : ite_interval_timer_checker

bind ite_interval_timer ite_interval_timer_checker chk (.clk(clk), .srst(srst), .avsAddress(avsAddress),
  .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
  .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .extIrqFirst(extIrqFirst),
  .extIrqSecond(extIrqSecond), .extIrqThird(extIrqThird), .watchTimerOut(watchTimerOut),
  .cpuHalt(cpuHalt), .compareMatchIrq(compareMatchIrq), .irq(irq));
`default_nettype wire

// ===== sim/tb.sv
// self-checking testbench for the interval timer with edge select
`default_nettype none
module tb
  import ite_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [ITE_ADDR_W-1:0] avsAddress = '0;
  logic [31:0] avsWritedata = '0;
  logic [31:0] avsReaddata;
  logic [3:0] avsByteenable = 4'hF;
  logic avsRead = 1'b0, avsWrite = 1'b0, avsWaitrequest, compareMatchIrq, irq, wave = 1'b0;
  logic extIrqFirst = 1'b0, extIrqSecond = 1'b0, extIrqThird = 1'b0, watchTimerOut = 1'b0, cpuHalt = 1'b0;
  int nMismatch = 0, samplesChecked = 0;
  // ****************************************
  // clock, waves and design
  // ****************************************
  initial forever #2 clk = ~clk;
  // square wave on watch output and first input, six cycles a period
  initial forever
  begin
    repeat (3) @(posedge clk);
    if (wave)
    begin
      watchTimerOut <= ~watchTimerOut;
      extIrqFirst <= ~extIrqFirst;
    end
  end
  ite_interval_timer dut (.clk(clk), .srst(srst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .extIrqFirst(extIrqFirst),
    .extIrqSecond(extIrqSecond), .extIrqThird(extIrqThird), .watchTimerOut(watchTimerOut),
    .cpuHalt(cpuHalt), .compareMatchIrq(compareMatchIrq), .irq(irq));
  // verdict and end of run
  task automatic completeRun();
    $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : completeRun
  task automatic expire();
    nMismatch++;
    $display("[FAIL] wait expected done seen timeout");
    completeRun();
  endtask : expire
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one avalon access, held until wait request is seen low
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    @(posedge clk);
    avsAddress <= {idx, 2'h0};
    avsWrite <= wr;
    avsRead <= ~wr;
    avsWritedata <= wd;
    k = 0;
    // waitrequest is read at the rising edge itself, before that edge's updates land
    do
    begin
      @(posedge clk);
      k++;
    end
    while (avsWaitrequest !== 1'b0 && k < 9);
    if (avsWaitrequest !== 1'b0)
      expire();
    rd = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask : bus
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask : wr
  task automatic rdck(input string what, input logic [15:0] idx, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, idx, 32'h0, r);
    check(what, r, e);
  endtask : rdck
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask : waitc
  // cycles between two compare pulses
  task automatic gap(output int n);
    int hits;
    hits = 0;
    n = 0;
    for (int k = 0; k < 500 && hits < 2; k++)
    begin
      @(negedge clk);
      if (hits == 1)
        n++;
      if (compareMatchIrq === 1'b1)
        hits++;
    end
    if (hits < 2)
      expire();
  endtask : gap
  // ****************************************
  // scenarios
  // ****************************************
  task automatic testRegs();
    rdck("edge reset", IDX_EXTERNAL_EDGE_MODE, 32'h0);
    rdck("sample reset", IDX_SAMPLE_CLOCK_SELECT, 32'h0);
    rdck("unmapped", 16'h0123, 32'h0);
    wr(IDX_EXTERNAL_EDGE_MODE, 32'hFF);
    rdck("edge fields", IDX_EXTERNAL_EDGE_MODE, 32'hFC);
    wr(IDX_SAMPLE_CLOCK_SELECT, 32'hFF);
    rdck("sample field", IDX_SAMPLE_CLOCK_SELECT, 32'h3);
    $display("registers done");
  endtask : testRegs
  task automatic testEdges();
    logic [31:0] r;
    logic [1:0] code[3] = '{EDGE_FALL, EDGE_RISE, EDGE_BOTH};
    wr(IDX_IRQ_MASK, 32'h6);
    foreach (code[i])
    begin
      wr(IDX_EXTERNAL_EDGE_MODE, {24'h0, code[i], code[i], 4'h0});
      bus(1'b0, IDX_IRQ_STATUS, 32'h0, r);
      extIrqSecond <= 1'b1;
      extIrqThird <= 1'b1;
      waitc(3);
      check("irq rise", {31'h0, irq}, {31'h0, code[i] != EDGE_FALL});
      rdck("rise", IDX_IRQ_STATUS, code[i] != EDGE_FALL ? 32'h6 : 32'h0);
      waitc(1); // status clears on the accepting edge, irq drops at that same edge since it is combinational
      check("irq read", {31'h0, irq}, 32'h0);
      extIrqSecond <= 1'b0;
      extIrqThird <= 1'b0;
      waitc(3);
      rdck("fall", IDX_IRQ_STATUS, code[i] != EDGE_RISE ? 32'h6 : 32'h0);
    end
    wr(IDX_IRQ_MASK, 32'h0);
    extIrqSecond <= 1'b1;
    waitc(3);
    check("irq masked", {31'h0, irq}, 32'h0);
    rdck("masked", IDX_IRQ_STATUS, 32'h2);
    $display("edges done");
  endtask : testEdges
  task automatic testFilter();
    logic [31:0] r;
    int osc[8] = '{1, 1, 1, 0, 0, 0, 1, 0};
    int sel[8] = '{2, 3, 1, 2, 3, 1, 0, 0};
    int cpuN[8] = '{0, 0, 0, 0, 0, 0, 3, 2};
    int ex[8] = '{5, 6, 7, 6, 7, 8, 3, 3};
    wr(IDX_TIMER_MODE_CONTROL, 32'h0);
    wr(IDX_EXTERNAL_EDGE_MODE, 32'h0C);
    wr(IDX_OSC_MODE, 32'h1);
    wr(IDX_SAMPLE_CLOCK_SELECT, 32'h2);
    bus(1'b0, IDX_IRQ_STATUS, 32'h0, r);
    extIrqFirst <= 1'b1;
    @(posedge clk);
    extIrqFirst <= 1'b0;
    waitc(100);
    rdck("noise", IDX_IRQ_STATUS, 32'h0);
    foreach (ex[i])
    begin
      wr(IDX_OSC_MODE, 32'(osc[i]));
      wr(IDX_CPU_CLOCK_CONTROL, 32'(cpuN[i]));
      wr(IDX_SAMPLE_CLOCK_SELECT, 32'(sel[i]));
      extIrqFirst <= ~extIrqFirst;
      waitc((1 << ex[i]) - 8);
      rdck("early", IDX_IRQ_STATUS, 32'h0);
      waitc((1 << ex[i]) + 10);
      rdck("sampled", IDX_IRQ_STATUS, 32'h1);
    end
    cpuHalt <= 1'b1;
    extIrqFirst <= ~extIrqFirst;
    waitc(40);
    rdck("halted", IDX_IRQ_STATUS, 32'h0);
    cpuHalt <= 1'b0;
    waitc(20);
    rdck("resumed", IDX_IRQ_STATUS, 32'h1);
    $display("filter done");
  endtask : testFilter
  task automatic testInterval();
    logic [31:0] r;
    int n;
    int osc[12] = '{0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 1};
    int code[12] = '{1, 2, 3, 4, 2, 3, 4, 1, 5, 6, 7, 0};
    int span[12] = '{5, 10, 20, 40, 5, 10, 20, 0, 0, 0, 30, 30};
    wr(IDX_TIMER_MODE_CONTROL, 32'h0);
    wr(IDX_EXTERNAL_EDGE_MODE, 32'h04);
    wr(IDX_SAMPLE_CLOCK_SELECT, 32'h0);
    wr(IDX_CPU_CLOCK_CONTROL, 32'h0);
    wr(IDX_COMPARE_ZERO, 32'h4);
    wr(IDX_IRQ_MASK, 32'h8);
    wave <= 1'b1;
    foreach (span[i])
    begin
      wr(IDX_TIMER_MODE_CONTROL, 32'h0);
      wr(IDX_OSC_MODE, 32'(osc[i]));
      wr(IDX_TIMER_CLOCK_SELECT, 32'(code[i] << 4));
      wr(IDX_TIMER_MODE_CONTROL, {28'h0, MODE_INTERVAL, 1'b0});
      if (span[i] > 0)
      begin
        gap(n);
        check("interval", 32'(n), 32'(span[i]));
      end
      else
      begin
        waitc(30);
        rdck("held count", IDX_TIMER_COUNT, 32'h0);
      end
    end
    wave <= 1'b0;
    check("cmp irq", {31'h0, irq}, 32'h1);
    bus(1'b0, IDX_IRQ_STATUS, 32'h0, r);
    check("cmp status", r & 32'h8, 32'h8);
    wr(IDX_TIMER_MODE_CONTROL, 32'h0);
    bus(1'b0, IDX_IRQ_STATUS, 32'h0, r);
    waitc(1); // status clears on the accepting edge, irq drops at that same edge since it is combinational
    check("irq cleared", {31'h0, irq}, 32'h0);
    rdck("stopped", IDX_TIMER_COUNT, 32'h0);
    $display("interval done");
  endtask : testInterval
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    testRegs();
    testEdges();
    testFilter();
    testInterval();
    completeRun();
  end
endmodule : tb
`default_nettype wire
